// [hdl/wake_defs.svh]
// Purpose: Named offsets, field positions, reset values and timing for the wake-up logic.
// Assumes: Register indexes times four give APB byte addresses.
// Notes: Definitions only.
`ifndef WAKE_DEFS_SVH
`define WAKE_DEFS_SVH
// ----------------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------------
`define IDX_TIMER_CONTROL 10'h088
`define IDX_RTC_CONFIG 10'h0A1
`define IDX_RTC_CONFIG_TWO 10'h0A2
`define IDX_PORT0_PULLUP 10'h0B2
`define IDX_PORT1_PULLUP 10'h0B3
`define IDX_PORT2_PULLUP 10'h0B4
`define IDX_POWER_CONTROL 10'h0C5
`define IDX_WAKE_STATUS 10'h0E0
`define IDX_WAKE_MASK 10'h0E1
`define IDX_WAKE_ENABLE 10'h0E2
`define IDX_POWER_IRQ_ENABLE 10'h0EC
`define IDX_TEMP_SUPPLY_DELTA 10'h0F3
`define IDX_PERIPHERAL_CONFIG 10'h0F4
`define IDX_POWER_IRQ_FLAGS 10'h0F8
`define IDX_SCRATCH0 10'h0FB
`define IDX_IRQ_PIN_CONFIG 10'h0FF
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TC_PIN0_EDGE_SELECT 0
`define TC_PIN1_EDGE_SELECT 2
`define RTC_INTERVAL_FLAG 2
`define RTC_ALARM_FLAG 6
`define RTC_FLAG_MASK 8'h44
`define RTC2_ALARM_EN_MASK 8'h3F
`define PIC_PIN0_WAKE_ENABLE 0
`define PIC_PIN1_HI 3
`define PIC_PIN1_LO 2
`define PWR_SLEEP_BIT 4
`define PWR_LCD_SLEEP_ON 0
`define PIE_SUPPLY_ADC_WAKE 3
`define PIF_SUPPLY_ADC_CHANGE 3
`define PIF_SUPPLY_RESTORED 7
`define DELTA_TEMP_SLEEP_MASK 8'hE0
`define PER_RX_HI 1
`define PER_RX_LO 0
`define PER_RAIL_SOURCE 6
`define PER_RX_EDGE_FLAG 7
`define PER_RW_MASK 8'h3F
`define WEN_TEMP 0
`define WEN_RTC_INTERVAL 1
// Wake status bit positions.
`define WS_TEMP 0
`define WS_SUPPLY_ADC 1
`define WS_RESTORED 2
`define WS_INTERVAL 3
`define WS_ALARM 4
`define WS_PIN0 5
`define WS_PIN1 6
`define WS_RX 7
`define WS_RESET 8
// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define BYTE_ZERO 8'h00
`define PULLUP_RESET 8'hFF
`define STATUS_ZERO 9'h000
`define CLK_PERIOD_NS 50
`define POWERUP_NS 400
`define POWERUP_CYC (`POWERUP_NS / `CLK_PERIOD_NS)
`define CNT_ONE 4'h1
`endif

// [hdl/wake_pkg.sv]
// Purpose: Types shared by the wake-up logic.
// Assumes: Field widths as in wake_defs.svh.
// Notes: Holds types only.
package wake_pkg;
   typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_POWERUP} power_state_e;
   typedef struct packed {
      logic [7:0] timer_control;
      logic [7:0] rtc_config;
      logic [7:0] rtc_config_two;
      logic [7:0] port0_pullup_enable;
      logic [7:0] port1_pullup_enable;
      logic [7:0] port2_pullup_enable;
      logic [7:0] power_control;
      logic [8:0] wake_status;
      logic [8:0] wake_mask;
      logic [7:0] wake_enable;
      logic [7:0] power_irq_enable;
      logic [7:0] temp_supply_delta;
      logic [7:0] peripheral_config;
      logic [7:0] power_irq_flags;
      logic [3:0][7:0] retained_scratch_regs;
      logic [7:0] irq_pin_config;
   } regs_s;
   typedef struct packed {
      logic temp_change;
      logic supply_adc_change;
      logic supply_restored;
      logic rail_to_battery;
      logic rtc_interval;
      logic rtc_alarm;
   } peripheral_config_evt_s;
endpackage

// [hdl/sleep_wakeup_event_logic.sv]
// Purpose: Always-on sleep and wake-up control with its APB register file.
// Assumes: All inputs synchronous to pclk; event inputs are one-cycle pulses.
// Notes: Registers at byte address four times their index.
// Summary of operation
// [R1] - Software clears wake flag before sleeping again.
// [R2] - Temperature change wakes unless sleep measurement off.
// [R3] - Supply ADC change sets flag bit 3.
// [R4] - Supply ADC wake gated by enable bit 3.
// [R5] - Supply restore always wakes, sets rail bit.
// [R6] - RTC interval wakes, sets interval flag.
// [R7] - RTC alarm wakes when alarm enables set.
// [R8] - Pin 0 wakes when enabled, edge selectable.
// [R9] - Pin 0 wake leaves its edge flag.
// [R10] - Pin 1 wakes on field 11x, flag unchanged.
// [R11] - Receive line edge wakes, sets edge flag.
// [R12] - Reset pin low always wakes from sleep.
// [R13] - LCD switchable in sleep, memory retained.
// [R14] - Four scratch registers retained through sleep.
// [R15] - Pins inputs in sleep, pull-ups per bit.
// [R16] - Software sets power control bit 4 to sleep.
// [R17] - Wake restarts core from reset vector.
// [R18] - Wake requests merged and registered before power-up.
`include "wake_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_event_logic
   import wake_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire peripheral_config_evt_s peripheral_config_evt,
   input wire logic ext_irq0_n,
   input wire logic ext_irq1_n,
   input wire logic second_uart_rx_line,
   input wire logic ext_reset_n,
   output logic sleep_mode,
   output logic battery_mode,
   output logic core_power_on,
   output logic core_reset_n,
   output logic rtc_vector,
   output logic power_mgmt_vector,
   output logic lcd_enable,
   output logic io_force_input,
   output logic [23:0] pullup_enable,
   output logic irq
);
   // ----------------------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------------------
   localparam logic [3:0] POWERUP_LAST = 4'(`POWERUP_CYC - 1);

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   regs_s regs_q;
   regs_s regs_d;
   power_state_e state_q;
   power_state_e state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic wake_req_q;
   logic wake_req_d;
   logic pin0_prev_q;
   logic pin1_prev_q;
   logic rx_prev_q;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pslverr_q;
   logic pslverr_d;
   logic ack_q;

   // ----------------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------------
   logic access;
   logic wr;
   logic [9:0] idx;
   logic [7:0] wb;
   logic mapped;
   logic [31:0] rdata;

   assign access = psel & penable;
   // The access phase spans two edges; a second write would undo a flag set between them.
   assign wr = access & pwrite & ~ack_q;
   assign idx = paddr[11:2];
   assign wb = pwdata[7:0];

   always_comb begin
      mapped = 1'b1;
      rdata = 32'h0000_0000;
      case (idx)
         `IDX_TIMER_CONTROL: rdata[7:0] = regs_q.timer_control;
         `IDX_RTC_CONFIG: rdata[7:0] = regs_q.rtc_config;
         `IDX_RTC_CONFIG_TWO: rdata[7:0] = regs_q.rtc_config_two;
         `IDX_PORT0_PULLUP: rdata[7:0] = regs_q.port0_pullup_enable;
         `IDX_PORT1_PULLUP: rdata[7:0] = regs_q.port1_pullup_enable;
         `IDX_PORT2_PULLUP: rdata[7:0] = regs_q.port2_pullup_enable;
         `IDX_POWER_CONTROL: rdata[7:0] = regs_q.power_control;
         `IDX_WAKE_STATUS: rdata[8:0] = regs_q.wake_status;
         `IDX_WAKE_MASK: rdata[8:0] = regs_q.wake_mask;
         `IDX_WAKE_ENABLE: rdata[7:0] = regs_q.wake_enable;
         `IDX_POWER_IRQ_ENABLE: rdata[7:0] = regs_q.power_irq_enable;
         `IDX_TEMP_SUPPLY_DELTA: rdata[7:0] = regs_q.temp_supply_delta;
         `IDX_PERIPHERAL_CONFIG: rdata[7:0] = regs_q.peripheral_config;
         `IDX_POWER_IRQ_FLAGS: rdata[7:0] = regs_q.power_irq_flags;
         `IDX_IRQ_PIN_CONFIG: rdata[7:0] = regs_q.irq_pin_config;
         default: begin
            if (idx >= `IDX_SCRATCH0 && idx < `IDX_IRQ_PIN_CONFIG) begin
               rdata[7:0] = regs_q.retained_scratch_regs[2'(idx - `IDX_SCRATCH0)];
            end else begin
               mapped = 1'b0;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // Wake sources
   // ----------------------------------------------------------------------------
   logic asleep;
   logic ev_temp;
   logic ev_alarm;
   logic pin0_trig;
   logic pin1_trig;
   logic pin0_wake;
   logic pin1_wake;
   logic rx_edge;
   logic rx_wake;
   logic reset_wake;
   logic [8:0] wake_evt;
   logic [8:0] wake_gate;

   assign asleep = (state_q == ST_SLEEP);
   // Temperature events are dropped when sleep measurement is switched off.
   assign ev_temp = peripheral_config_evt.temp_change
                  & ((regs_q.temp_supply_delta & `DELTA_TEMP_SLEEP_MASK) != `BYTE_ZERO); // [R2]
   assign ev_alarm = peripheral_config_evt.rtc_alarm
                   & ((regs_q.rtc_config_two & `RTC2_ALARM_EN_MASK) != `BYTE_ZERO); // [R7]
   // Edge select one: falling edge; zero: low level, as on the timer interrupts.
   assign pin0_trig = regs_q.timer_control[`TC_PIN0_EDGE_SELECT]
                    ? (pin0_prev_q & ~ext_irq0_n) : ~ext_irq0_n; // [R8]
   assign pin1_trig = regs_q.timer_control[`TC_PIN1_EDGE_SELECT]
                    ? (pin1_prev_q & ~ext_irq1_n) : ~ext_irq1_n; // [R10]
   assign pin0_wake = pin0_trig & regs_q.irq_pin_config[`PIC_PIN0_WAKE_ENABLE]; // [R8]
   assign pin1_wake = pin1_trig
                    & (regs_q.irq_pin_config[`PIC_PIN1_HI:`PIC_PIN1_LO] == 2'b11); // [R10]
   assign rx_edge = rx_prev_q ^ second_uart_rx_line;
   assign rx_wake = rx_edge
                  & (regs_q.peripheral_config[`PER_RX_HI:`PER_RX_LO] == 2'b11); // [R11]
   assign reset_wake = ~ext_reset_n & asleep; // [R12]

   always_comb begin
      wake_evt = `STATUS_ZERO;
      wake_evt[`WS_TEMP] = ev_temp;
      wake_evt[`WS_SUPPLY_ADC] = peripheral_config_evt.supply_adc_change;
      wake_evt[`WS_RESTORED] = peripheral_config_evt.supply_restored;
      wake_evt[`WS_INTERVAL] = peripheral_config_evt.rtc_interval;
      wake_evt[`WS_ALARM] = ev_alarm;
      wake_evt[`WS_PIN0] = pin0_wake;
      wake_evt[`WS_PIN1] = pin1_wake;
      wake_evt[`WS_RX] = rx_wake;
      wake_evt[`WS_RESET] = reset_wake;
      // Restore and reset pin carry no mask.
      wake_gate = {9{1'b1}};
      wake_gate[`WS_TEMP] = regs_q.wake_enable[`WEN_TEMP]; // [R2]
      wake_gate[`WS_SUPPLY_ADC] = regs_q.power_irq_enable[`PIE_SUPPLY_ADC_WAKE]; // [R4]
      wake_gate[`WS_INTERVAL] = regs_q.wake_enable[`WEN_RTC_INTERVAL]; // [R6]
   end

   // ----------------------------------------------------------------------------
   // Register file next state
   // ----------------------------------------------------------------------------
   // Every sticky flag below applies its write-one clear first and its hardware
   // set after, so an event in the clearing cycle is kept.
   always_comb begin
      regs_d = regs_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      if (access) begin
         pslverr_d = ~mapped;
         prdata_d = pwrite ? prdata_q : rdata;
      end
      if (wr && mapped) begin
         case (idx)
            `IDX_TIMER_CONTROL: regs_d.timer_control = wb;
            `IDX_RTC_CONFIG: begin
               regs_d.rtc_config = (wb & ~`RTC_FLAG_MASK)
                                 | (regs_q.rtc_config & `RTC_FLAG_MASK & ~wb); // [R1]
            end
            `IDX_RTC_CONFIG_TWO: regs_d.rtc_config_two = wb;
            `IDX_PORT0_PULLUP: regs_d.port0_pullup_enable = wb;
            `IDX_PORT1_PULLUP: regs_d.port1_pullup_enable = wb;
            `IDX_PORT2_PULLUP: regs_d.port2_pullup_enable = wb;
            `IDX_POWER_CONTROL: regs_d.power_control = wb;
            `IDX_WAKE_STATUS: regs_d.wake_status = regs_q.wake_status & ~pwdata[8:0]; // [R1]
            `IDX_WAKE_MASK: regs_d.wake_mask = pwdata[8:0];
            `IDX_WAKE_ENABLE: regs_d.wake_enable = wb;
            `IDX_POWER_IRQ_ENABLE: regs_d.power_irq_enable = wb;
            `IDX_TEMP_SUPPLY_DELTA: regs_d.temp_supply_delta = wb;
            `IDX_PERIPHERAL_CONFIG: begin
               regs_d.peripheral_config[5:0] = wb[5:0];
               regs_d.peripheral_config[`PER_RX_EDGE_FLAG] =
                  regs_q.peripheral_config[`PER_RX_EDGE_FLAG] & ~wb[`PER_RX_EDGE_FLAG]; // [R1]
            end
            `IDX_POWER_IRQ_FLAGS: regs_d.power_irq_flags = regs_q.power_irq_flags & ~wb; // [R1]
            `IDX_IRQ_PIN_CONFIG: regs_d.irq_pin_config = wb;
            default: begin
               regs_d.retained_scratch_regs[2'(idx - `IDX_SCRATCH0)] = wb; // [R14]
            end
         endcase
      end
      // The sleep request bit is a command and never reads back as one.
      regs_d.power_control[`PWR_SLEEP_BIT] = 1'b0;
      if (peripheral_config_evt.supply_adc_change) begin
         regs_d.power_irq_flags[`PIF_SUPPLY_ADC_CHANGE] = 1'b1; // [R3]
      end
      if (peripheral_config_evt.supply_restored) begin
         regs_d.power_irq_flags[`PIF_SUPPLY_RESTORED] = 1'b1; // [R5]
         regs_d.peripheral_config[`PER_RAIL_SOURCE] = 1'b1; // [R5]
      end else if (peripheral_config_evt.rail_to_battery) begin
         regs_d.peripheral_config[`PER_RAIL_SOURCE] = 1'b0;
      end
      if (peripheral_config_evt.rtc_interval) begin
         regs_d.rtc_config[`RTC_INTERVAL_FLAG] = 1'b1; // [R6]
      end
      if (ev_alarm) begin
         regs_d.rtc_config[`RTC_ALARM_FLAG] = 1'b1; // [R7]
      end
      if (rx_wake) begin
         regs_d.peripheral_config[`PER_RX_EDGE_FLAG] = 1'b1; // [R11]
      end
      // Pin wakes touch nothing in timer_control, so its edge flags stay put.
      regs_d.wake_status = regs_d.wake_status | (wake_evt & wake_gate); // [R9]
   end

   // ----------------------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      wake_req_d = asleep & ((wake_evt & wake_gate) != `STATUS_ZERO); // [R18]
      case (state_q)
         ST_AWAKE: begin
            if (wr && idx == `IDX_POWER_CONTROL && wb[`PWR_SLEEP_BIT]) begin
               state_d = ST_SLEEP; // [R16]
            end
         end
         ST_SLEEP: begin
            if (wake_req_q) begin
               state_d = ST_POWERUP; // [R18]
               cnt_d = 4'h0;
            end
         end
         ST_POWERUP: begin
            if (cnt_q == POWERUP_LAST) begin
               state_d = ST_AWAKE;
            end else begin
               cnt_d = cnt_q + `CNT_ONE;
            end
         end
         default: state_d = ST_AWAKE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regs_q <= '0;
         regs_q.port0_pullup_enable <= `PULLUP_RESET;
         regs_q.port1_pullup_enable <= `PULLUP_RESET;
         regs_q.port2_pullup_enable <= `PULLUP_RESET;
         state_q <= ST_AWAKE;
         cnt_q <= 4'h0;
         wake_req_q <= 1'b0;
         pin0_prev_q <= 1'b1;
         pin1_prev_q <= 1'b1;
         rx_prev_q <= 1'b1;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         regs_q <= regs_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         wake_req_q <= wake_req_d;
         pin0_prev_q <= ext_irq0_n;
         pin1_prev_q <= ext_irq1_n;
         rx_prev_q <= second_uart_rx_line;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------
   // Read data lands one edge after the access phase opens, so pready waits
   // one cycle; this keeps prdata a flop output.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access & ~ack_q;
      end
   end

   assign pready = ack_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & ack_q;
   assign sleep_mode = asleep;
   // Battery mode starts only once the core leaves its power-up reset.
   assign battery_mode = (state_q == ST_AWAKE) & ~regs_q.peripheral_config[`PER_RAIL_SOURCE];
   assign core_power_on = ~asleep;
   // Holding the core in reset until power-up ends restarts it at its reset vector.
   assign core_reset_n = (state_q == ST_AWAKE); // [R17]
   assign rtc_vector = (regs_q.rtc_config & `RTC_FLAG_MASK) != `BYTE_ZERO; // [R6] [R7]
   assign power_mgmt_vector = regs_q.power_irq_flags[`PIF_SUPPLY_ADC_CHANGE]
                            | regs_q.power_irq_flags[`PIF_SUPPLY_RESTORED]; // [R3] [R5]
   // LCD memory sits in this always-on domain; only the drive is switched.
   assign lcd_enable = ~asleep | regs_q.power_control[`PWR_LCD_SLEEP_ON]; // [R13]
   assign io_force_input = asleep; // [R15]
   assign pullup_enable = {regs_q.port2_pullup_enable, regs_q.port1_pullup_enable,
                           regs_q.port0_pullup_enable}; // [R15]
   assign irq = (regs_q.wake_status & regs_q.wake_mask) != `STATUS_ZERO;
endmodule
`default_nettype wire

// [tb/wake_partner.sv]
// Purpose: Pins and always-on peripherals that face the wake-up logic.
// Assumes: Bench calls the tasks from one process at a time.
// Notes: Pins idle high, as their pull-ups would hold them.
`timescale 1ns/1ps
`default_nettype none
module wake_partner
   import wake_pkg::*;
(
   input wire logic pclk,
   output peripheral_config_evt_s peripheral_config_evt,
   output logic ext_irq0_n,
   output logic ext_irq1_n,
   output logic rx_line,
   output logic ext_reset_n
);
   initial begin
      peripheral_config_evt = '0;
      ext_irq0_n = 1'b1;
      ext_irq1_n = 1'b1;
      rx_line = 1'b1;
      ext_reset_n = 1'b1;
   end
   // Events are single-cycle pulses, so a stuck event cannot hide a missed edge.
   task pulse(input int b);
      @(posedge pclk);
      peripheral_config_evt[b] <= 1'b1;
      @(posedge pclk);
      peripheral_config_evt[b] <= 1'b0;
   endtask
   task drive(input int pin, input logic v);
      @(posedge pclk);
      case (pin)
         0: ext_irq0_n <= v;
         1: ext_irq1_n <= v;
         2: rx_line <= v;
         default: ext_reset_n <= v;
      endcase
   endtask
endmodule
`default_nettype wire

// [tb/wake_checker_sva.sv]
// Purpose: Port-level timing checks of the wake-up logic.
// Assumes: Register byte address is four times its index.
// Notes: Attached to every instance of the block.
`include "wake_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module wake_checker
   import wake_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire peripheral_config_evt_s peripheral_config_evt,
   input wire logic ext_reset_n,
   input wire logic sleep_mode,
   input wire logic battery_mode,
   input wire logic core_power_on,
   input wire logic core_reset_n,
   input wire logic lcd_enable,
   input wire logic io_force_input,
   input wire logic [23:0] pullup_enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_io_as_input: assert property (io_force_input == sleep_mode)
      else $error("io force differs from sleep");
   chk_sleep_cmd: assert property (psel && penable && pwrite && !pready && core_reset_n &&
      paddr == {`IDX_POWER_CONTROL, 2'b00} && pwdata[`PWR_SLEEP_BIT] |-> ##[1:3] sleep_mode)
      else $error("sleep command ignored");
   chk_reset_wake: assert property (sleep_mode && !ext_reset_n |-> ##[1:2] !sleep_mode)
      else $error("reset pin did not wake");
   chk_restore_wake: assert property (sleep_mode && peripheral_config_evt.supply_restored |-> ##[1:2] !sleep_mode)
      else $error("restore did not wake");
   chk_powerup_len: assert property ($rose(core_power_on) |-> !core_reset_n [*8] ##1 core_reset_n)
      else $error("power-up length wrong");
   chk_core_off: assert property (sleep_mode |-> !core_power_on && !core_reset_n)
      else $error("core alive in sleep");
   chk_lcd_awake: assert property (core_reset_n |-> lcd_enable)
      else $error("lcd off while awake");
   chk_battery_awake: assert property (battery_mode |-> core_reset_n && !sleep_mode)
      else $error("battery mode while not awake");
   chk_pullups_kept: assert property (sleep_mode && $past(sleep_mode) && !psel |-> $stable(pullup_enable))
      else $error("pull-ups changed in sleep");
endmodule
bind sleep_wakeup_event_logic wake_checker wake_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .peripheral_config_evt(peripheral_config_evt), .ext_reset_n(ext_reset_n), .sleep_mode(sleep_mode), .battery_mode(battery_mode),
   .core_power_on(core_power_on), .core_reset_n(core_reset_n), .lcd_enable(lcd_enable),
   .io_force_input(io_force_input), .pullup_enable(pullup_enable));
`default_nettype wire

// [tb/sleep_wakeup_event_logic_tb.sv]
// Purpose: Self-checking bench of the wake-up logic over APB.
// Assumes: Event bit order as in peripheral_config_evt_s, MSB first.
// Notes: Each wake source is tried from sleep, enabled; pin 0, temperature and supply ADC are also tried disabled.
`include "wake_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module sleep_wakeup_event_logic_tb
   import wake_pkg::*;
;
   localparam int EV_TEMP = 5, EV_ADC = 4, EV_REST = 3, EV_BATT = 2, EV_INT = 1, EV_ALARM = 0;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, err, ext_irq0_n, ext_irq1_n, rx_line, ext_reset_n;
   logic sleep_mode, battery_mode, core_power_on, core_reset_n, rtc_vector, power_mgmt_vector;
   logic lcd_enable, io_force_input, irq;
   logic [23:0] pullup_enable;
   peripheral_config_evt_s peripheral_config_evt;
   int errors = 0, compares = 0;
   always #25 pclk = ~pclk;
   sleep_wakeup_event_logic sleep_wakeup_event_logic_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .peripheral_config_evt(peripheral_config_evt), .ext_irq0_n(ext_irq0_n), .ext_irq1_n(ext_irq1_n),
      .second_uart_rx_line(rx_line), .ext_reset_n(ext_reset_n), .sleep_mode(sleep_mode),
      .battery_mode(battery_mode), .core_power_on(core_power_on), .core_reset_n(core_reset_n),
      .rtc_vector(rtc_vector), .power_mgmt_vector(power_mgmt_vector), .lcd_enable(lcd_enable),
      .io_force_input(io_force_input), .pullup_enable(pullup_enable), .irq(irq));
   wake_partner wake_partner_inst (.pclk(pclk), .peripheral_config_evt(peripheral_config_evt), .ext_irq0_n(ext_irq0_n),
      .ext_irq1_n(ext_irq1_n), .rx_line(rx_line), .ext_reset_n(ext_reset_n));
   task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave.
      do begin @(posedge pclk); end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task rdchk(input logic [9:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      `CHK(rd[7:0], exp)
   endtask
   task go_sleep(input logic [7:0] pc);
      apb(1'b1, `IDX_WAKE_STATUS, 32'h0000_01FF);
      apb(1'b1, `IDX_POWER_IRQ_FLAGS, 32'h0000_00FF);
      apb(1'b1, `IDX_RTC_CONFIG, 32'h0000_0044);
      apb(1'b1, `IDX_POWER_CONTROL, {24'h00_0000, pc | 8'h10});
      repeat (4) @(posedge pclk);
      `CHK(sleep_mode, 1'b1)
   endtask
   // Bounded so that a lost wake shows as a mismatch, not a hang.
   task wait_wake;
      int n;
      n = 0;
      while (core_reset_n !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
      `CHK(core_reset_n, 1'b1)
   endtask
   task t_reset;
      rdchk(`IDX_PORT0_PULLUP, 8'hFF);
      `CHK(pullup_enable, 24'hFF_FFFF)
      apb(1'b1, `IDX_PORT1_PULLUP, 32'h0000_00A5);
      `CHK(pullup_enable[15:8], 8'hA5)
      apb(1'b0, 10'h001, 32'h0000_0000);
      `CHK(err, 1'b1)
      `CHK(irq, 1'b0)
   endtask
   task t_pin0;
      apb(1'b1, `IDX_SCRATCH0, 32'h0000_005A);
      apb(1'b1, `IDX_IRQ_PIN_CONFIG, 32'h0000_0001);
      apb(1'b1, `IDX_TIMER_CONTROL, 32'h0000_0001);
      apb(1'b1, `IDX_WAKE_MASK, 32'h0000_0020);
      go_sleep(8'h00);
      `CHK(lcd_enable, 1'b0)
      `CHK(io_force_input, 1'b1)
      wake_partner_inst.drive(0, 1'b0);
      wait_wake();
      wake_partner_inst.drive(0, 1'b1);
      `CHK(core_reset_n, 1'b1)
      `CHK(battery_mode, 1'b1)
      rdchk(`IDX_SCRATCH0, 8'h5A);
      rdchk(`IDX_PORT1_PULLUP, 8'hA5);
      rdchk(`IDX_TIMER_CONTROL, 8'h01);
      `CHK(irq, 1'b1)
      apb(1'b1, `IDX_WAKE_STATUS, 32'h0000_0020);
      `CHK(irq, 1'b0)
   endtask
   task t_pin1_reset;
      apb(1'b1, `IDX_IRQ_PIN_CONFIG, 32'h0000_000C);
      apb(1'b1, `IDX_TIMER_CONTROL, 32'h0000_0004);
      go_sleep(8'h01);
      `CHK(lcd_enable, 1'b1)
      wake_partner_inst.drive(0, 1'b0);
      repeat (20) @(posedge pclk);
      `CHK(sleep_mode, 1'b1)
      wake_partner_inst.drive(0, 1'b1);
      wake_partner_inst.drive(1, 1'b0);
      wait_wake();
      wake_partner_inst.drive(1, 1'b1);
      `CHK(core_reset_n, 1'b1)
      rdchk(`IDX_TIMER_CONTROL, 8'h04);
      go_sleep(8'h00);
      wake_partner_inst.drive(3, 1'b0);
      wait_wake();
      wake_partner_inst.drive(3, 1'b1);
      `CHK(battery_mode, 1'b1)
   endtask
   task t_supply;
      apb(1'b1, `IDX_POWER_IRQ_ENABLE, 32'h0000_0000);
      apb(1'b1, `IDX_TEMP_SUPPLY_DELTA, 32'h0000_0000);
      apb(1'b1, `IDX_WAKE_ENABLE, 32'h0000_0001);
      go_sleep(8'h00);
      wake_partner_inst.pulse(EV_ADC);
      wake_partner_inst.pulse(EV_TEMP);
      repeat (20) @(posedge pclk);
      `CHK(sleep_mode, 1'b1)
      rdchk(`IDX_POWER_IRQ_FLAGS, 8'h08);
      `CHK(power_mgmt_vector, 1'b1)
      apb(1'b1, `IDX_POWER_IRQ_FLAGS, 32'h0000_00FF);
      apb(1'b1, `IDX_POWER_IRQ_ENABLE, 32'h0000_0008);
      wake_partner_inst.pulse(EV_ADC);
      wait_wake();
      `CHK(core_reset_n, 1'b1)
      apb(1'b1, `IDX_TEMP_SUPPLY_DELTA, 32'h0000_0020);
      go_sleep(8'h00);
      wake_partner_inst.pulse(EV_TEMP);
      wait_wake();
      `CHK(core_reset_n, 1'b1)
      go_sleep(8'h00);
      wake_partner_inst.pulse(EV_REST);
      wait_wake();
      rdchk(`IDX_PERIPHERAL_CONFIG, 8'h40);
      `CHK(battery_mode, 1'b0)
      wake_partner_inst.pulse(EV_BATT);
      rdchk(`IDX_PERIPHERAL_CONFIG, 8'h00);
   endtask
   task t_rtc_rx;
      apb(1'b1, `IDX_WAKE_ENABLE, 32'h0000_0002);
      go_sleep(8'h00);
      wake_partner_inst.pulse(EV_INT);
      wait_wake();
      rdchk(`IDX_RTC_CONFIG, 8'h04);
      `CHK(rtc_vector, 1'b1)
      apb(1'b1, `IDX_RTC_CONFIG_TWO, 32'h0000_0001);
      go_sleep(8'h00);
      wake_partner_inst.pulse(EV_ALARM);
      wait_wake();
      rdchk(`IDX_RTC_CONFIG, 8'h40);
      apb(1'b1, `IDX_PERIPHERAL_CONFIG, 32'h0000_0083);
      go_sleep(8'h00);
      wake_partner_inst.drive(2, 1'b0);
      wait_wake();
      rdchk(`IDX_PERIPHERAL_CONFIG, 8'h83);
      wake_partner_inst.drive(2, 1'b1);
   endtask
   task finish_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pin0();
      t_pin1_reset();
      t_supply();
      t_rtc_rx();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      finish_test();
   end
endmodule
`default_nettype wire
